/* File: design/mms_dev_end.sv */
`timescale 1ns/100ps
module mms_dev_end
    import mms_pkg::*;
#(
    parameter logic [31:0] IMPL_MASK = mms_pkg::IMPL_MASK_DEF
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    mms_mdio_if.device                       mdio_bus,
    input  wire logic [mms_pkg::ADDR_W-1:0]  strapped_phy_address,
    output logic                             synced,
    output logic                             frame_error,
    output logic                             wr_strobe,
    output logic      [mms_pkg::ADDR_W-1:0]  wr_addr,
    output logic      [mms_pkg::REG_W-1:0]   wr_data,
    output logic      [mms_pkg::ADDR_W-1:0]  own_addr
);
    import mms_pkg::*;

    logic                  mdc_s;
    logic                  mdio_s;
    logic [ADDR_W-1:0]     strap_s;
    logic                  mdc_p_q;
    mms_dev_state_t        state_q;
    logic [5:0]            cnt_q;
    logic [REG_W-1:0]      sh_q;
    logic [REG_W-1:0]      rd_sh_q;
    logic [ADDR_W-1:0]     phy_q;
    logic [ADDR_W-1:0]     reg_q;
    logic                  is_rd_q;
    logic                  hit_q;
    logic                  latch_pend_q;
    logic                  drive_q;
    logic                  drive_oe_q;
    logic                  pullup_q;
    logic                  synced_q;
    logic                  err_q;
    logic                  wr_strobe_q;
    logic [ADDR_W-1:0]     wr_addr_q;
    logic [REG_W-1:0]      wr_data_q;
    logic [ADDR_W-1:0]     own_q;
    logic [REG_W-1:0]      regs_q [NUM_REGS];

    // Register read decode; holes read as zero
    function automatic logic [REG_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
        reg_read = IMPL_MASK[a] ? regs_q[a] : REG_RST;
    endfunction

    mms_sync #(.W(ADDR_W + 2)) u_sync (
        .sys_clk (sys_clk),
        .d       ({mdio_bus.mdc, mdio_bus.mdio, strapped_phy_address}),
        .q       ({mdc_s, mdio_s, strap_s})
    );

    // Decoding
    wire       rise     = mdc_s & ~mdc_p_q;
    wire       b        = mdio_s;
    wire [1:0] op_now   = {sh_q[0], b};
    wire       op_ok    = (op_now == OP_READ) || (op_now == OP_WRITE);
    wire [4:0] reg_now  = {sh_q[3:0], b};
    wire       bcast_en = regs_q[CTRL_TWO_IDX][BCAST_BIT];
    wire       own_hit  = (phy_q == own_q);
    wire       bc_hit   = bcast_en && (phy_q == BCAST_ADDR) && !is_rd_q;
    wire       rd_hit   = is_rd_q && hit_q;
    wire       last_cnt = (cnt_q[4:0] == DATA_LAST);
    wire       ta_bad   = !is_rd_q && (b != (cnt_q[0] ? TA_WRITE[0]
                                                      : TA_WRITE[1]));
    wire       bad_now  = rise && (((state_q == ST_START) && !b) ||
                                   ((state_q == ST_OP) && cnt_q[0] && !op_ok) ||
                                   ((state_q == ST_TA) && ta_bad));
    wire       commit   = rise && (state_q == ST_DATA) && last_cnt &&
                          !is_rd_q && hit_q;
    wire       store    = commit && IMPL_MASK[reg_q] &&
                          (reg_q != STATUS_IDX);
    wire [15:0] wr_word = {sh_q[14:0], b};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_PRE;
            cnt_q   <= 6'h00;
            sh_q    <= 16'h0000;
            phy_q   <= 5'h00;
            reg_q   <= 5'h00;
            is_rd_q <= 1'b0;
            hit_q   <= 1'b0;
            rd_sh_q <= 16'h0000;
        end else if (bad_now) begin
            state_q <= ST_PRE;
            cnt_q   <= 6'h00;
        end else if (rise) begin
            unique case (state_q)
                ST_PRE: begin
                    cnt_q <= b ? cnt_q + 6'h01 : 6'h00;
                    if (b && (cnt_q == PRE_LEN - 6'h01)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // One idle bit suffices between frames
                    if (!b) begin
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    state_q <= ST_OP;
                    cnt_q   <= 6'h00;
                end
                ST_OP: begin
                    sh_q  <= wr_word;
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q[0]) begin
                        is_rd_q <= (op_now == OP_READ);
                        state_q <= ST_PHY;
                        cnt_q   <= 6'h00;
                    end
                end
                ST_PHY: begin
                    sh_q  <= wr_word;
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q[4:0] == FIELD_LAST) begin
                        phy_q   <= reg_now;
                        state_q <= ST_REG;
                        cnt_q   <= 6'h00;
                    end
                end
                ST_REG: begin
                    sh_q  <= wr_word;
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q[4:0] == FIELD_LAST) begin
                        reg_q   <= reg_now;
                        hit_q   <= own_hit || bc_hit;
                        rd_sh_q <= reg_read(reg_now);
                        state_q <= ST_TA;
                        cnt_q   <= 6'h00;
                    end
                end
                ST_TA: begin
                    cnt_q <= 6'h01;
                    if (cnt_q[0]) begin
                        state_q <= ST_DATA;
                        cnt_q   <= 6'h00;
                        rd_sh_q <= {rd_sh_q[14:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    sh_q    <= wr_word;
                    cnt_q   <= cnt_q + 6'h01;
                    rd_sh_q <= {rd_sh_q[14:0], 1'b0};
                    if (last_cnt) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Line driver: changes only just after a sampled rise
    always_ff @(posedge sys_clk) begin
        if (rst || bad_now) begin
            drive_q    <= 1'b1;
            drive_oe_q <= 1'b0;
        end else if (rise && rd_hit && (state_q == ST_TA)) begin
            // First turnaround bit stays released, zero follows
            drive_oe_q <= 1'b1;
            drive_q    <= cnt_q[0] ? rd_sh_q[15] : 1'b0;
        end else if (rise && rd_hit && (state_q == ST_DATA)) begin
            drive_oe_q <= !last_cnt;
            drive_q    <= last_cnt ? 1'b1 : rd_sh_q[15];
        end
    end

    // Register array; status register is read-only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= (i == int'(STATUS_IDX)) ? STATUS_RST
                                                     : REG_RST;
            end
        end else if (store) begin
            regs_q[reg_q] <= wr_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mdc_p_q      <= 1'b0;
            latch_pend_q <= 1'b1;
            own_q        <= 5'h00;
            pullup_q     <= 1'b0;
            synced_q     <= 1'b0;
            err_q        <= 1'b0;
            wr_strobe_q  <= 1'b0;
            wr_addr_q    <= 5'h00;
            wr_data_q    <= 16'h0000;
        end else begin
            mdc_p_q      <= mdc_s;
            latch_pend_q <= 1'b0;
            // Strap caught once, on the first cycle after release
            if (latch_pend_q) begin
                own_q <= strap_s;
            end
            pullup_q    <= regs_q[CABLE_DIAG_IDX][PULL_EN_BIT];
            err_q       <= bad_now;
            wr_strobe_q <= store;
            if (store) begin
                wr_addr_q <= reg_q;
                wr_data_q <= wr_word;
            end
            if (bad_now) begin
                synced_q <= 1'b0;
            end else if (rise && (state_q == ST_PRE) && b &&
                         (cnt_q == PRE_LEN - 6'h01)) begin
                synced_q <= 1'b1;
            end
        end
    end

    assign mdio_bus.mdio_dev_o  = drive_q;
    assign mdio_bus.mdio_dev_oe = drive_oe_q;
    assign mdio_bus.pullup_en   = pullup_q;
    assign synced               = synced_q;
    assign frame_error          = err_q;
    assign wr_strobe            = wr_strobe_q;
    assign wr_addr              = wr_addr_q;
    assign wr_data              = wr_data_q;
    assign own_addr             = own_q;
endmodule

/* File: design/mms_host_end.sv */
`timescale 1ns/100ps
module mms_host_end
    import mms_pkg::*;
#(
    parameter int MDC_HALF = mms_pkg::MDC_HALF_CYC
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    mms_mdio_if.host                         mdio_bus,
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire logic                        cmd_write,
    input  wire logic                        cmd_preamble,
    input  wire logic [mms_pkg::ADDR_W-1:0]  cmd_phy,
    input  wire logic [mms_pkg::ADDR_W-1:0]  cmd_reg,
    input  wire logic [mms_pkg::REG_W-1:0]   cmd_wdata,
    output logic                             rsp_valid,
    output logic      [mms_pkg::REG_W-1:0]   rsp_rdata
);
    import mms_pkg::*;

    logic            mdio_s;
    logic [7:0]      div_q;
    logic            mdc_q;
    mms_host_state_t state_q;
    logic [4:0]      cnt_q;
    logic [31:0]     tx_q;
    logic [15:0]     rx_q;
    logic            wr_q;
    logic            pre_q;
    logic            have_q;
    logic            o_q;
    logic            oe_q;
    logic            ready_q;
    logic            rsp_q;
    logic [15:0]     rdata_q;

    mms_sync #(.W(1)) u_sync (
        .sys_clk (sys_clk),
        .d       (mdio_bus.mdio),
        .q       (mdio_s)
    );

    // Default MDC_HALF keeps the clock under the 25 MHz ceiling; an override is not checked
    wire tick      = (div_q == 8'(MDC_HALF - 1));
    wire rise_tick = tick && !mdc_q;
    wire fall_tick = tick && mdc_q;
    wire accept    = cmd_valid && ready_q;
    // Data changes mid-bit, after the rise the device sampled
    wire step      = fall_tick;
    wire [31:0] frame_w = {START_PAT, cmd_write ? OP_WRITE : OP_READ,
                           cmd_phy, cmd_reg,
                           cmd_write ? TA_WRITE : TA_IDLE,
                           cmd_write ? cmd_wdata : 16'hffff};
    // Reads release the line from the first turnaround bit on
    wire next_oe = wr_q || ((cnt_q - 5'h01) >= HOST_DRIVE_MIN);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_q <= 8'h00;
            mdc_q <= 1'b0;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            if (tick) begin
                mdc_q <= !mdc_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= H_IDLE;
            cnt_q   <= 5'h00;
            tx_q    <= 32'h0000_0000;
            rx_q    <= 16'h0000;
            wr_q    <= 1'b0;
            pre_q   <= 1'b0;
            have_q  <= 1'b0;
            o_q     <= 1'b1;
            oe_q    <= 1'b0;
            ready_q <= 1'b1;
            rsp_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            rsp_q <= 1'b0;
            if (accept) begin
                tx_q    <= frame_w;
                wr_q    <= cmd_write;
                pre_q   <= cmd_preamble;
                have_q  <= 1'b1;
                ready_q <= 1'b0;
            end
            if (rise_tick && (state_q == H_FRAME) && !wr_q &&
                (cnt_q < TA_LOW_IDX)) begin
                rx_q <= {rx_q[14:0], mdio_s};
            end
            if (step) begin
                unique case (state_q)
                    H_IDLE: begin
                        if (have_q) begin
                            have_q <= 1'b0;
                            cnt_q  <= FRAME_LAST;
                            oe_q   <= 1'b1;
                            if (pre_q) begin
                                state_q <= H_PRE;
                                o_q     <= 1'b1;
                            end else begin
                                state_q <= H_FRAME;
                                o_q     <= tx_q[31];
                                tx_q    <= {tx_q[30:0], 1'b1};
                            end
                        end
                    end
                    H_PRE: begin
                        cnt_q <= cnt_q - 5'h01;
                        if (cnt_q == 5'h00) begin
                            state_q <= H_FRAME;
                            cnt_q   <= FRAME_LAST;
                            o_q     <= tx_q[31];
                            tx_q    <= {tx_q[30:0], 1'b1};
                        end
                    end
                    H_FRAME: begin
                        cnt_q <= cnt_q - 5'h01;
                        if (cnt_q == 5'h00) begin
                            state_q <= H_GAP;
                            oe_q    <= 1'b0;
                            o_q     <= 1'b1;
                        end else begin
                            o_q  <= tx_q[31];
                            oe_q <= next_oe;
                            tx_q <= {tx_q[30:0], 1'b1};
                        end
                    end
                    H_GAP: begin
                        // Released idle bit closes the frame
                        state_q <= H_IDLE;
                        ready_q <= 1'b1;
                        rsp_q   <= 1'b1;
                        rdata_q <= wr_q ? 16'h0000 : rx_q;
                    end
                endcase
            end
        end
    end

    assign mdio_bus.mdc          = mdc_q;
    assign mdio_bus.mdio_host_o  = o_q;
    assign mdio_bus.mdio_host_oe = oe_q;
    assign cmd_ready             = ready_q;
    assign rsp_valid             = rsp_q;
    assign rsp_rdata             = rdata_q;
endmodule

/* File: design/mms_mdio_if.sv */
`timescale 1ns/100ps
interface mms_mdio_if;
    logic mdc;
    logic mdio_dev_o;
    logic mdio_dev_oe;
    logic mdio_host_o;
    logic mdio_host_oe;
    logic pullup_en;
    wire  mdio;

    // Released line reads high: the board pull-up is mandatory
    assign mdio = mdio_dev_oe  ? mdio_dev_o  :
                  mdio_host_oe ? mdio_host_o : 1'b1;

    modport device (
        input  mdc,
        input  mdio,
        output mdio_dev_o,
        output mdio_dev_oe,
        output pullup_en
    );

    modport host (
        output mdc,
        output mdio_host_o,
        output mdio_host_oe,
        input  mdio
    );
endinterface

/* File: design/mms_pkg.sv */
package mms_pkg;

    // Frame geometry
    localparam int ADDR_W    = 5;
    localparam int REG_W     = 16;
    localparam int NUM_REGS  = 32;
    localparam int FRAME_LEN = 32;

    localparam logic [5:0] PRE_LEN    = 6'h20;
    localparam logic [4:0] FRAME_LAST = 5'h1f;
    localparam logic [4:0] FIELD_LAST = 5'h04;
    localparam logic [4:0] DATA_LAST  = 5'h0f;
    localparam logic [4:0] TA_LOW_IDX = 5'h10;
    localparam logic [4:0] HOST_DRIVE_MIN = 5'h12;

    localparam logic [1:0] START_PAT = 2'b01;
    localparam logic [1:0] OP_READ   = 2'b10;
    localparam logic [1:0] OP_WRITE  = 2'b01;
    localparam logic [1:0] TA_WRITE  = 2'b10;
    localparam logic [1:0] TA_IDLE   = 2'b11;

    // Register map
    localparam logic [4:0] BCAST_ADDR     = 5'h1f;
    localparam logic [4:0] STATUS_IDX     = 5'h01;
    localparam logic [4:0] CABLE_DIAG_IDX = 5'h1b;
    localparam logic [4:0] CTRL_TWO_IDX   = 5'h1c;
    localparam int         PRE_SUPPRESS_BIT = 6;
    localparam int         BCAST_BIT        = 11;
    localparam int         PULL_EN_BIT      = 5;

    localparam logic [15:0] STATUS_RST = 16'h0040;
    localparam logic [15:0] REG_RST    = 16'h0000;
    localparam logic [31:0] IMPL_MASK_DEF = 32'h1800_00ff;

    // Management clock limits
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int MDC_MIN_PERIOD_NS = 40;
    localparam int MDC_HALF_CYC =
        (MDC_MIN_PERIOD_NS / 2 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_PRE   = 3'b000,
        ST_IDLE  = 3'b001,
        ST_START = 3'b010,
        ST_OP    = 3'b011,
        ST_PHY   = 3'b100,
        ST_REG   = 3'b101,
        ST_TA    = 3'b110,
        ST_DATA  = 3'b111
    } mms_dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_PRE   = 2'b01,
        H_FRAME = 2'b10,
        H_GAP   = 2'b11
    } mms_host_state_t;

endpackage

/* File: design/mms_sync.sv */
`timescale 1ns/100ps
module mms_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // No reset, so straps are already valid while rst is held
    always_ff @(posedge sys_clk) begin
        meta_q <= d;
        q      <= meta_q;
    end
endmodule

/* File: dv/mdio_management_slave_tb.sv */
`timescale 1ns/100ps
module mdio_management_slave_tb;
    import mms_pkg::*;
    localparam logic [5:0] BAD [4] = '{6'b000110, 6'b010010,
                                       6'b011110, 6'b010111};
    localparam logic [31:0] GOOD = {START_PAT, OP_WRITE, 5'h05, 5'h02,
                                    TA_WRITE, 16'h1234};
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic        cmd_preamble = 1'b0;
    logic [4:0]  cmd_phy = 5'h00;
    logic [4:0]  cmd_reg = 5'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [4:0]  strap = 5'h01;
    logic        cmd_ready, rsp_valid, synced, frame_error, wr_strobe;
    logic [15:0] rsp_rdata, wr_data, data_b;
    logic [4:0]  wr_addr, own_addr, addr_b, rg, phy;
    logic        synced_b, err_b, strobe_b;
    logic [15:0] mdl [32];
    int          errors, total_checks, strb_cnt, strb_b_cnt, err_b_cnt;
    int          err_cnt;
    bit          drove, dev_sync;
    int unsigned seed_v;

    mms_mdio_if bus();
    mms_mdio_if bus2();
    mms_dev_end i_mms_dev_end (
        .sys_clk(sys_clk), .rst(rst), .mdio_bus(bus.device),
        .strapped_phy_address(strap), .synced(synced),
        .frame_error(frame_error), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .own_addr(own_addr));
    mms_dev_end i_mms_dev_end_b (
        .sys_clk(sys_clk), .rst(rst), .mdio_bus(bus2.device),
        .strapped_phy_address(5'h05), .synced(synced_b),
        .frame_error(err_b), .wr_strobe(strobe_b),
        .wr_addr(addr_b), .wr_data(data_b), .own_addr());
    mms_host_end #(.MDC_HALF(3)) i_mms_host_end (
        .sys_clk(sys_clk), .rst(rst), .mdio_bus(bus.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_preamble(cmd_preamble),
        .cmd_phy(cmd_phy), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    mms_mdio_monitor #(.MDC_HALF(3)) i_mms_mdio_monitor (
        .sys_clk(sys_clk), .rst(rst), .mdc(bus.mdc),
        .mdio_dev_o(bus.mdio_dev_o), .mdio_dev_oe(bus.mdio_dev_oe),
        .mdio_host_o(bus.mdio_host_o), .mdio_host_oe(bus.mdio_host_oe),
        .pullup_en(bus.pullup_en), .mdio(bus.mdio));

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (bus.mdio_dev_oe === 1'b1) drove = 1'b1;
        if (wr_strobe === 1'b1) strb_cnt++;
        if (strobe_b === 1'b1) strb_b_cnt++;
        if (err_b === 1'b1) err_b_cnt++;
        if (frame_error === 1'b1) err_cnt++;
    end

    task automatic check(input bit ok, input string what);
        total_checks++;
        if (!ok) begin
            errors++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        dev_sync = 1'b0;
        for (int k = 0; k < 32; k++) mdl[k] = REG_RST;
        mdl[STATUS_IDX] = STATUS_RST;
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic do_cmd(input bit wr, pre, input logic [4:0] p, r,
                          input logic [15:0] wd);
        int n;
        n = 0;
        @(negedge sys_clk);
        drove = 1'b0;
        cmd_valid = 1'b1;
        {cmd_write, cmd_preamble, cmd_phy, cmd_reg} = {wr, pre, p, r};
        cmd_wdata = wd;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        check(cmd_ready === 1'b0, "command not taken");
        while (rsp_valid !== 1'b1) begin
            @(negedge sys_clk);
            if (++n > 1000) begin
                errors++;
                $display("MISMATCH at %0t: no response", $time);
                test_done();
            end
        end
        check(cmd_ready === 1'b1, "ready after response");
    endtask

    task automatic rd(input logic [4:0] p, r, input bit pre);
        bit hit;
        logic [15:0] exp;
        dev_sync |= pre;
        hit = dev_sync && p === strap;
        // Unanswered frames read the pulled-up line
        exp = !hit ? 16'hffff : IMPL_MASK_DEF[r] ? mdl[r] : 16'h0000;
        do_cmd(1'b0, pre, p, r, 16'h0000);
        check(rsp_rdata === exp, "read data");
        check(drove == hit, "device drive");
    endtask

    task automatic wr(input logic [4:0] p, r, input logic [15:0] d,
                      input bit pre);
        bit hit;
        int c0;
        dev_sync |= pre;
        hit = dev_sync && (p === strap || p === BCAST_ADDR
            && mdl[CTRL_TWO_IDX][BCAST_BIT]);
        hit = hit && IMPL_MASK_DEF[r] && r !== STATUS_IDX;
        c0 = strb_cnt;
        do_cmd(1'b1, pre, p, r, d);
        if (hit) mdl[r] = d;
        check(strb_cnt == c0 + int'(hit), "strobe");
        check(rsp_rdata === 16'h0000, "write response data");
        if (hit) check(wr_addr === r && wr_data === d, "store");
    endtask

    // Bench-made link clock, still between frames
    task automatic send2(input logic [31:0] bits);
        for (int k = 31; k >= 0; k--) begin
            bus2.mdc = 1'b0;
            bus2.mdio_host_o = bits[k];
            bus2.mdio_host_oe = 1'b1;
            #80;
            bus2.mdc = 1'b1;
            #80;
        end
        bus2.mdc = 1'b0;
        bus2.mdio_host_oe = 1'b0;
        // One released idle bit, the least allowed between frames
        #80;
        bus2.mdc = 1'b1;
        #80;
        bus2.mdc = 1'b0;
        #400;
    endtask

    initial begin
        int c;
        bus2.mdc = 1'b0;
        bus2.mdio_host_o = 1'b1;
        bus2.mdio_host_oe = 1'b0;
        seed_v = $urandom(32'h176b98e4);
        strap = 5'h01 + 5'($urandom % 30);
        do_reset();
        check(own_addr === strap, "own address");
        check(synced === 1'b0, "sync after reset");
        rd(strap, STATUS_IDX, 1'b0);
        rd(strap, STATUS_IDX, 1'b1);
        check(synced === 1'b1, "sync after preamble");
        rd(strap, 5'h00, 1'b0);
        for (int i = 0; i < 60; i++) begin
            rg = 5'($urandom);
            phy = ($urandom % 4 == 0) ? 5'($urandom) : strap;
            if ($urandom % 2) wr(phy, rg, 16'($urandom), 1'($urandom));
            else rd(phy, rg, 1'($urandom));
        end
        check(bus.pullup_en === mdl[CABLE_DIAG_IDX][PULL_EN_BIT], "pull");
        wr(strap, CTRL_TWO_IDX, 16'h0000, 1'b0);
        wr(BCAST_ADDR, 5'h03, 16'h5a5a, 1'b0);
        rd(strap, 5'h03, 1'b0);
        wr(strap, CTRL_TWO_IDX, 16'h0800, 1'b0);
        wr(BCAST_ADDR, 5'h03, 16'ha5c3, 1'b0);
        rd(strap, 5'h03, 1'b0);
        rd(BCAST_ADDR, 5'h03, 1'b0);
        wr(strap, CABLE_DIAG_IDX, 16'h0020, 1'b0);
        check(bus.pullup_en === 1'b1, "pull-up on");
        wr(strap, STATUS_IDX, 16'hffbf, 1'b0);
        rd(strap, STATUS_IDX, 1'b0);
        wr(strap, 5'h0a, 16'hbeef, 1'b0);
        rd(strap, 5'h0a, 1'b0);
        check(err_cnt == 0, "frame error on clean bus");
        #1.3;
        send2(32'hffff_ffff);
        send2(GOOD);
        check(strb_b_cnt == 1 && addr_b === 5'h02, "link write");
        check(data_b === 16'h1234, "link data");
        for (int i = 0; i < 4; i++) begin
            c = strb_b_cnt;
            send2({BAD[i][5:2], 5'h05, 5'h02, BAD[i][1:0], 16'h1234});
            check(err_b_cnt == i + 1 && synced_b === 1'b0, "bad frame");
            send2(GOOD);
            check(strb_b_cnt == c, "frame not ignored");
            send2(32'hffff_ffff);
            send2(GOOD);
            check(strb_b_cnt == c + 1, "no resync");
        end
        @(negedge sys_clk);
        do_reset();
        rd(strap, STATUS_IDX, 1'b0);
        rd(strap, 5'h03, 1'b1);
        test_done();
    end
endmodule

/* File: dv/mms_mdio_monitor.sv */
`timescale 1ns/100ps
module mms_mdio_monitor #(
    parameter int MDC_HALF = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_dev_o,
    input wire logic mdio_dev_oe,
    input wire logic mdio_host_o,
    input wire logic mdio_host_oe,
    input wire logic pullup_en,
    input wire logic mdio
);
    localparam int SPAN = 34 * MDC_HALF;
    int oe_cnt_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Turnaround zero plus sixteen data bits: 17 bit times of drive
    always_ff @(posedge sys_clk) begin
        if (rst || !mdio_dev_oe) begin
            oe_cnt_q <= 0;
        end else begin
            oe_cnt_q <= oe_cnt_q + 1;
        end
    end

    sequence s_mdc_hi;
        mdc [*3];
    endsequence
    sequence s_mdc_lo;
        !mdc [*3];
    endsequence
    // Device sees mdc through a synchroniser, so allow a short window
    sequence s_rise_ago;
        $past(mdc, 2) && !$past(mdc, 3) || $past(mdc, 3) && !$past(mdc, 4)
            || $past(mdc, 4) && !$past(mdc, 5);
    endsequence

    a_no_contention:
        assert property (!(mdio_dev_oe && mdio_host_oe))
        else $error("both ends drive the data line");
    a_mdc_high:
        assert property ($rose(mdc) |-> s_mdc_hi)
        else $error("mdc high phase too short");
    a_mdc_low:
        assert property ($fell(mdc) |-> s_mdc_lo)
        else $error("mdc low phase too short");
    a_host_mid_bit:
        assert property (mdc && $past(mdc) |->
            $stable(mdio_host_o) && $stable(mdio_host_oe))
        else $error("host data moved while mdc high");
    a_dev_after_rise:
        assert property ($changed(mdio_dev_o) || $changed(mdio_dev_oe)
            |-> s_rise_ago)
        else $error("device output moved away from an mdc rise");
    a_ta_zero:
        assert property ($rose(mdio_dev_oe) |-> !mdio_dev_o)
        else $error("second turnaround bit not zero");
    a_ta_released:
        assert property ($rose(mdio_dev_oe) |->
            !$past(mdio_host_oe, 1) && !$past(mdio_host_oe, 5))
        else $error("first turnaround bit was driven");
    a_release_high:
        assert property ($fell(mdio_host_oe) |-> mdio [*3])
        else $error("released line not high");
    a_host_gap:
        assert property ($fell(mdio_host_oe) |-> !mdio_host_oe [*6])
        else $error("idle bit between frames missing");
    a_drive_span:
        assert property ($fell(mdio_dev_oe) |->
            oe_cnt_q inside {[SPAN-1:SPAN+1]})
        else $error("device drive length wrong");
    a_data_hold:
        assert property ($changed(mdio_dev_o) && mdio_dev_oe |=>
            $stable(mdio_dev_o) [*4])
        else $error("device data bit too short");

    cover property ($rose(pullup_en));
    cover property ($rose(mdio_dev_oe));
endmodule
